// [fsg_pkg.sv]
// shared constants and types of the flash rewrite security guard
package fsg_pkg;

  localparam int BLK_W = 8;
  localparam int BLOCK_BYTES = 1024;
  localparam int CLUSTER_BYTES = 4096;
  localparam int CLUSTER_BLOCKS = CLUSTER_BYTES / BLOCK_BYTES;
  localparam logic [BLK_W-1:0] CLUSTER_BLK = BLK_W'(CLUSTER_BLOCKS);
  localparam logic [BLK_W-1:0] WIN_START_RST = {BLK_W{1'b0}};
  localparam logic [BLK_W-1:0] WIN_END_RST = {BLK_W{1'b1}};

  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] START_CNT_RST = 2'h3;
  localparam logic [1:0] START_CNT_SAMPLE = 2'h1;
  localparam logic [1:0] PIN_PROG = 2'h3;

  typedef enum logic [1:0] {
    CMD_CHIP_ERASE,
    CMD_BLK_ERASE,
    CMD_WRITE,
    CMD_SEC_SET
  } fsg_cmd_e;

  typedef enum logic {
    SRC_SERIAL,
    SRC_SELF
  } fsg_src_e;

  typedef enum logic [1:0] {
    RSP_ACK,
    RSP_NAK,
    RSP_SUSP
  } fsg_rsp_e;

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } fsg_state_e;

  typedef struct packed {
    logic chipProt;
    logic blkProt;
    logic wrProt;
    logic boot0Prot;
    logic bootSwap;
    logic [BLK_W-1:0] winStart;
    logic [BLK_W-1:0] winEnd;
  } fsg_cfg_s;

  localparam fsg_cfg_s CFG_FACTORY = '{
    chipProt: 1'b0, blkProt: 1'b0, wrProt: 1'b0, boot0Prot: 1'b0,
    bootSwap: 1'b0, winStart: WIN_START_RST, winEnd: WIN_END_RST};

  typedef struct packed {
    fsg_cmd_e cmd;
    fsg_src_e src;
    logic [BLK_W-1:0] block;
    fsg_cfg_s cfg;
  } fsg_req_s;

endpackage

// [fsg_guard.sv]
// flash rewrite security guard: gates erase, write and security-set requests
//
// Overview of operation
// - new protection settings only act from the next programming-mode entry
// - chip-erase prohibition rejects serial chip erase and block erase
// - once chip erase is prohibited, no prohibition can be cleared but by nvClearn
// - block-erase prohibition rejects serial block erase, self path still erases
// - write prohibition rejects serial write and block erase, self path still writes
// - boot-cluster-0 prohibition rejects chip erase and rewrites of cluster 0
// - factory state has no prohibitions; each may be set from either path
// - a completed chip erase returns all settings but boot-cluster-0 prohibition to factory state, unless the image prohibits chip erase
// - self path ignores chip, block and write prohibitions
// - serial chip erase stays allowed under block or write prohibition only
// - block and write prohibitions clear only by serial chip erase or nvClearn
// - self operations refused while cpu runs on subsystem clock
// - self operations refused in regulator low consumption mode
// - enabled interrupt suspends a self operation and vectors to the handler
// - boot swap exchanges the mapping of the two 4 KB boot clusters
// - swap state is sampled at reset so the next boot uses old cluster 1
// - self rewrites allowed only inside the shield window, inclusive
// - serial rewrites ignore the shield window
// - window bounds may be changed from either path
// - boot-cluster-0 prohibition wins over the shield window
`timescale 1ns/10ps
module fsg_guard
  import fsg_pkg::*;
(
  input wire logic clk, // 10 MHz device clock
  input wire logic resetn, // session reset, async, active low
  input wire logic nvClearn, // puts the nonvolatile image in factory state
  input wire logic flashModeSelectPin, // mode select pin, asynchronous
  input wire logic singleWireToolPin, // tool pin, asynchronous
  input wire logic selfModeEnter, // pulse: software enters self-programming
  input wire logic selfModeExit, // pulse: software leaves self-programming
  input wire logic cpuOnSubClk, // level: cpu clocked from subsystem clock
  input wire logic regLowPower, // level: regulator in low consumption mode
  input wire logic intReq, // level: unmasked interrupt request
  input wire logic intEnable, // level: global interrupt enable
  input wire logic reqValid, // pulse: request on req
  input wire fsg_req_s req, // request command, source, block, settings
  input wire logic flashDone, // pulse: flash array finished operation
  output logic reqReady, // guard can take a request
  output logic rspValid, // pulse: answer on rspCode
  output fsg_rsp_e rspCode, // ack, nak or suspended
  output logic flashGo, // pulse: start flash operation
  output fsg_cmd_e flashCmd, // operation for the flash array
  output logic [BLK_W-1:0] flashBlk, // physical block after swap
  output logic flashAbort, // pulse: stop running operation
  output logic suspendVector, // pulse: branch to interrupt handler
  output logic serialMode, // serial programming mode latched at reset
  output logic selfMode, // self-programming mode active
  output logic bootSwapActive, // swap in effect for this session
  output fsg_cfg_s activeCfg // settings gating this session
);

  logic [1:0] pinMeta_ff;
  logic [1:0] pinSync_ff;
  logic [1:0] nxt_pinMeta;
  logic [1:0] nxt_pinSync;

  fsg_cfg_s nv_ff;
  fsg_cfg_s nxt_nv;
  fsg_cfg_s act_ff;
  fsg_cfg_s nxt_act;
  fsg_state_e state_ff;
  fsg_state_e nxt_state;
  logic [1:0] startCnt_ff;
  logic [1:0] nxt_startCnt;
  logic serial_ff;
  logic nxt_serial;
  logic self_ff;
  logic nxt_self;
  logic ready_ff;
  logic nxt_ready;
  logic rspValid_ff;
  logic nxt_rspValid;
  fsg_rsp_e rspCode_ff;
  fsg_rsp_e nxt_rspCode;
  logic flashGo_ff;
  logic nxt_flashGo;
  fsg_cmd_e flashCmd_ff;
  fsg_cmd_e nxt_flashCmd;
  logic [BLK_W-1:0] flashBlk_ff;
  logic [BLK_W-1:0] nxt_flashBlk;
  logic abort_ff;
  logic nxt_abort;
  logic susp_ff;
  logic nxt_susp;
  logic pendSelf_ff;
  logic nxt_pendSelf;

  function automatic logic inBoot0(input logic [BLK_W-1:0] blk);
    inBoot0 = blk < CLUSTER_BLK;
  endfunction

  // logical to physical block: clusters 0 and 1 trade places under swap
  function automatic logic [BLK_W-1:0] swapMap(input logic [BLK_W-1:0] blk,
                                               input logic swap);
    logic [BLK_W-1:0] twoClusters;
    twoClusters = BLK_W'(2 * CLUSTER_BLOCKS);
    if (swap && blk < twoClusters) begin
      swapMap = blk ^ CLUSTER_BLK;
    end else begin
      swapMap = blk;
    end
  endfunction

  // pins come from outside; only the second stage is read
  always_comb begin
    nxt_pinMeta = {flashModeSelectPin, singleWireToolPin};
    nxt_pinSync = pinMeta_ff;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_ff <= 2'h0;
      pinSync_ff <= 2'h0;
    end else begin
      pinMeta_ff <= nxt_pinMeta;
      pinSync_ff <= nxt_pinSync;
    end
  end

  logic [BLK_W-1:0] physBlk;
  logic boot0Hit;
  logic inWin;
  logic serialReq;
  logic selfReq;
  logic selfOk;
  logic allow;
  logic isFlashOp;

  always_comb begin
    nxt_nv = nv_ff;
    nxt_act = act_ff;
    nxt_state = state_ff;
    nxt_startCnt = startCnt_ff;
    nxt_serial = serial_ff;
    nxt_self = self_ff;
    nxt_rspValid = 1'b0;
    nxt_rspCode = rspCode_ff;
    nxt_flashGo = 1'b0;
    nxt_flashCmd = flashCmd_ff;
    nxt_flashBlk = flashBlk_ff;
    nxt_abort = 1'b0;
    nxt_susp = 1'b0;
    nxt_pendSelf = pendSelf_ff;

    physBlk = swapMap(req.block, act_ff.bootSwap);
    boot0Hit = act_ff.boot0Prot && inBoot0(physBlk);
    inWin = req.block >= act_ff.winStart && req.block <= act_ff.winEnd;
    serialReq = req.src == SRC_SERIAL && serial_ff;
    selfReq = req.src == SRC_SELF && self_ff;
    selfOk = selfReq && !cpuOnSubClk && !regLowPower;
    isFlashOp = 1'b1;
    allow = 1'b0;

    // gating reads only the session copy, never the nonvolatile image
    case (req.cmd)
      CMD_CHIP_ERASE: begin
        allow = serialReq && !act_ff.chipProt && !act_ff.boot0Prot;
      end
      CMD_BLK_ERASE: begin
        allow = (serialReq && !act_ff.chipProt && !act_ff.blkProt
                 && !act_ff.wrProt && !boot0Hit)
             || (selfOk && !boot0Hit && inWin);
      end
      CMD_WRITE: begin
        allow = (serialReq && !act_ff.wrProt && !boot0Hit)
             || (selfOk && !boot0Hit && inWin);
      end
      CMD_SEC_SET: begin
        isFlashOp = 1'b0;
        allow = serialReq || selfOk;
      end
      default: begin
        allow = 1'b0;
      end
    endcase

    // settle the synchroniser before the strap is caught
    if (startCnt_ff != 2'h0) begin
      nxt_startCnt = startCnt_ff - 2'h1;
    end
    if (startCnt_ff == START_CNT_SAMPLE) begin
      nxt_serial = pinSync_ff == PIN_PROG;
      nxt_act = nv_ff;
    end

    if (selfModeEnter && !serial_ff && startCnt_ff == 2'h0 && state_ff == ST_IDLE) begin
      nxt_self = 1'b1;
      nxt_act = nv_ff;
    end else if (selfModeExit && state_ff == ST_IDLE) begin
      nxt_self = 1'b0;
    end

    case (state_ff)
      ST_IDLE: begin
        if (reqValid && ready_ff) begin
          if (!allow) begin
            nxt_rspValid = 1'b1;
            nxt_rspCode = RSP_NAK;
          end else if (!isFlashOp) begin
            // prohibitions can only be added, never removed, from here
            nxt_nv.chipProt = nv_ff.chipProt | req.cfg.chipProt;
            nxt_nv.blkProt = nv_ff.blkProt | req.cfg.blkProt;
            nxt_nv.wrProt = nv_ff.wrProt | req.cfg.wrProt;
            nxt_nv.boot0Prot = nv_ff.boot0Prot | req.cfg.boot0Prot;
            nxt_nv.bootSwap = req.cfg.bootSwap;
            nxt_nv.winStart = req.cfg.winStart;
            nxt_nv.winEnd = req.cfg.winEnd;
            nxt_rspValid = 1'b1;
            nxt_rspCode = RSP_ACK;
          end else begin
            nxt_flashGo = 1'b1;
            nxt_flashCmd = req.cmd;
            nxt_flashBlk = physBlk;
            nxt_pendSelf = req.src == SRC_SELF;
            nxt_state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (flashDone) begin
          nxt_rspValid = 1'b1;
          nxt_rspCode = RSP_ACK;
          nxt_state = ST_IDLE;
          // chip erase from a locked image clears nothing
          if (flashCmd_ff == CMD_CHIP_ERASE && !nv_ff.chipProt) begin
            nxt_nv = CFG_FACTORY;
            nxt_nv.boot0Prot = nv_ff.boot0Prot;
          end
        end else if (pendSelf_ff && intReq && intEnable) begin
          nxt_abort = 1'b1;
          nxt_susp = 1'b1;
          nxt_rspValid = 1'b1;
          nxt_rspCode = RSP_SUSP;
          nxt_self = 1'b0; // resume needs a fresh mode entry
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase

    nxt_ready = nxt_state == ST_IDLE && nxt_startCnt == 2'h0;
  end

  // the image survives session resets; nvClearn restores factory state, a completed chip erase all but boot0Prot
  always_ff @(posedge clk or negedge nvClearn) begin
    if (!nvClearn) begin
      nv_ff <= CFG_FACTORY;
    end else begin
      nv_ff <= nxt_nv;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_ff <= CFG_FACTORY;
      state_ff <= ST_IDLE;
      startCnt_ff <= START_CNT_RST;
      serial_ff <= 1'b0;
      self_ff <= 1'b0;
      ready_ff <= 1'b0;
      rspValid_ff <= 1'b0;
      rspCode_ff <= RSP_ACK;
      flashGo_ff <= 1'b0;
      flashCmd_ff <= CMD_CHIP_ERASE;
      flashBlk_ff <= {BLK_W{1'b0}};
      abort_ff <= 1'b0;
      susp_ff <= 1'b0;
      pendSelf_ff <= 1'b0;
    end else begin
      act_ff <= nxt_act;
      state_ff <= nxt_state;
      startCnt_ff <= nxt_startCnt;
      serial_ff <= nxt_serial;
      self_ff <= nxt_self;
      ready_ff <= nxt_ready;
      rspValid_ff <= nxt_rspValid;
      rspCode_ff <= nxt_rspCode;
      flashGo_ff <= nxt_flashGo;
      flashCmd_ff <= nxt_flashCmd;
      flashBlk_ff <= nxt_flashBlk;
      abort_ff <= nxt_abort;
      susp_ff <= nxt_susp;
      pendSelf_ff <= nxt_pendSelf;
    end
  end

  assign reqReady = ready_ff;
  assign rspValid = rspValid_ff;
  assign rspCode = rspCode_ff;
  assign flashGo = flashGo_ff;
  assign flashCmd = flashCmd_ff;
  assign flashBlk = flashBlk_ff;
  assign flashAbort = abort_ff;
  assign suspendVector = susp_ff;
  assign serialMode = serial_ff;
  assign selfMode = self_ff;
  assign bootSwapActive = act_ff.bootSwap;
  assign activeCfg = act_ff;

endmodule

// [fsg_flash_model.sv]
// flash array stand-in: finishes an operation after a set delay
`timescale 1ns/10ps
module fsg_flash_model (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic flashGo, // start
  input wire logic flashAbort, // cancel
  input wire logic [7:0] lat, // cycles to finish
  output logic flashDone // finished
);
  logic [7:0] cnt_ff;
  // an aborted operation must not report done later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_ff <= 8'h00;
    else if (flashGo) cnt_ff <= lat;
    else if (flashAbort) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end
  assign flashDone = cnt_ff == 8'h01;
endmodule

// [fsg_checker.sv]
// assertions on the ports of the security guard
`timescale 1ns/10ps
module fsg_checker
  import fsg_pkg::*;
(
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic cpuOnSubClk, // sub clock
  input wire logic regLowPower, // low power
  input wire logic intReq, // irq
  input wire logic intEnable, // irq enable
  input wire logic reqValid, // request
  input wire fsg_req_s req, // request body
  input wire logic flashDone, // done
  input wire logic reqReady, // ready
  input wire logic rspValid, // answer
  input wire fsg_rsp_e rspCode, // answer code
  input wire logic flashGo, // start
  input wire fsg_cmd_e flashCmd, // operation
  input wire logic suspendVector, // vector
  input wire logic serialMode, // serial
  input wire logic selfMode, // self
  input wire logic flashAbort, // abort
  input wire fsg_cfg_s activeCfg // settings
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take, ser, slf, nak;
  logic [BLK_W-1:0] phys;
  assign take = reqValid && reqReady;
  assign ser = take && req.src == SRC_SERIAL;
  assign slf = take && req.src == SRC_SELF;
  assign nak = rspValid && rspCode == RSP_NAK && !flashGo;
  assign phys = activeCfg.bootSwap && req.block < 8'h08 ? req.block ^ CLUSTER_BLK : req.block;
  slow_self_a: assert property (slf && (cpuOnSubClk || regLowPower) |=> nak)
    else $error("self request not refused");
  chip_lock_a: assert property (
    ser && activeCfg.chipProt && req.cmd inside {CMD_CHIP_ERASE, CMD_BLK_ERASE} |=> nak)
    else $error("erase passed chip lock");
  blk_lock_a: assert property (
    ser && activeCfg.blkProt && req.cmd == CMD_BLK_ERASE |=> nak)
    else $error("block erase passed lock");
  wr_lock_a: assert property (
    ser && activeCfg.wrProt && req.cmd inside {CMD_WRITE, CMD_BLK_ERASE} |=> nak)
    else $error("write passed lock");
  shield_win_a: assert property (
    slf && req.cmd inside {CMD_WRITE, CMD_BLK_ERASE} &&
    (req.block < activeCfg.winStart || req.block > activeCfg.winEnd) |=> nak)
    else $error("rewrite outside window");
  boot0_lock_a: assert property (
    take && activeCfg.boot0Prot && (req.cmd == CMD_CHIP_ERASE ||
    req.cmd != CMD_SEC_SET && phys < CLUSTER_BLK) |=> nak)
    else $error("boot cluster rewritten");
  chip_ok_a: assert property (
    ser && serialMode && req.cmd == CMD_CHIP_ERASE && !activeCfg.chipProt &&
    !activeCfg.boot0Prot |=> flashGo && flashCmd == CMD_CHIP_ERASE)
    else $error("chip erase refused");
  irq_susp_a: assert property (
    selfMode && !reqReady && !rspValid && !flashDone && intReq && intEnable
    |=> rspValid && rspCode == RSP_SUSP && suspendVector && flashAbort)
    else $error("interrupt did not suspend");
  self_free_a: assert property (
    slf && selfMode && !cpuOnSubClk && !regLowPower &&
    req.cmd inside {CMD_WRITE, CMD_BLK_ERASE} && req.block >= activeCfg.winStart &&
    req.block <= activeCfg.winEnd && !(activeCfg.boot0Prot && phys < CLUSTER_BLK) |=> flashGo)
    else $error("self rewrite refused");
endmodule
bind fsg_guard fsg_checker fsg_checker_i (.*);

// [flash_rewrite_security_guard_tb_top.sv]
// self-checking bench for the security guard
`timescale 1ns/10ps
module flash_rewrite_security_guard_tb_top;
  import fsg_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, nvClearn = 1'b0;
  logic flashModeSelectPin = 1'b1, singleWireToolPin = 1'b1;
  logic selfModeEnter = 1'b0, selfModeExit = 1'b0, cpuOnSubClk = 1'b0;
  logic regLowPower = 1'b0, intReq = 1'b0, intEnable = 1'b0, reqValid = 1'b0;
  logic flashDone, reqReady, rspValid, flashGo, flashAbort, suspendVector;
  logic serialMode, selfMode, bootSwapActive;
  logic [7:0] lat = 8'h04, gotBlk;
  logic [BLK_W-1:0] flashBlk;
  fsg_req_s req = '0;
  fsg_cfg_s cfgW, activeCfg;
  fsg_rsp_e rspCode;
  fsg_cmd_e flashCmd;
  int nMismatch = 0, testsRun = 0;
  always #50 clk = ~clk;
  fsg_guard fsg_guard_i (.*);
  fsg_flash_model fsg_flash_model_i (.*);
  task give_verdict;
    if (nMismatch == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pins held for the whole reset so the mode latch sees them settled
  task sess(input logic pin);
    @(posedge clk);
    #1 resetn = 1'b0;
    flashModeSelectPin = pin;
    singleWireToolPin = pin;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    nvClearn = 1'b1;
  endtask
  task automatic wait_ready;
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (reqReady !== 1'b1 && i < 50);
    if (i >= 50) begin nMismatch++; give_verdict; end
  endtask
  task mode(input logic ent);
    wait_ready;
    #1 selfModeEnter = ent;
    selfModeExit = !ent;
    @(posedge clk);
    #1 selfModeEnter = 1'b0;
    selfModeExit = 1'b0;
    chk(selfMode, ent);
  endtask
  task automatic send(input fsg_cmd_e cm, input fsg_src_e sr, input logic [7:0] bk,
      input fsg_rsp_e ex);
    int i;
    @(posedge clk);
    #1 req = '{cmd: cm, src: sr, block: bk, cfg: cfgW};
    reqValid = 1'b1;
    wait_ready;
    #1 reqValid = 1'b0;
    i = 0;
    while (rspValid !== 1'b1 && i < 100) begin
      if (flashGo === 1'b1) gotBlk = flashBlk;
      @(posedge clk);
      #1 i++;
    end
    if (i >= 100) begin nMismatch++; give_verdict; end
    chk(rspCode, ex);
  endtask
  initial begin
    cfgW = CFG_FACTORY;
    sess(1'b1);
    send(CMD_WRITE, SRC_SERIAL, 8'h00, RSP_ACK);
    chk(serialMode, 1'b1);
    cfgW.blkProt = 1'b1;
    cfgW.wrProt = 1'b1;
    cfgW.winStart = 8'h02;
    cfgW.winEnd = 8'h09;
    send(CMD_SEC_SET, SRC_SERIAL, 8'h00, RSP_ACK);
    send(CMD_BLK_ERASE, SRC_SERIAL, 8'h01, RSP_ACK);
    sess(1'b0);
    mode(1'b1);
    chk(serialMode, 1'b0);
    send(CMD_BLK_ERASE, SRC_SELF, 8'h03, RSP_ACK);
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_ACK);
    send(CMD_WRITE, SRC_SELF, 8'h0A, RSP_NAK);
    send(CMD_WRITE, SRC_SELF, 8'h01, RSP_NAK);
    send(CMD_CHIP_ERASE, SRC_SELF, 8'h00, RSP_NAK);
    cpuOnSubClk = 1'b1;
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_NAK);
    cpuOnSubClk = 1'b0;
    regLowPower = 1'b1;
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_NAK);
    regLowPower = 1'b0;
    intReq = 1'b1;
    intEnable = 1'b1;
    lat = 8'h28;
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_SUSP);
    chk(selfMode, 1'b0);
    intReq = 1'b0;
    lat = 8'h04;
    mode(1'b1);
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_ACK);
    // a pending interrupt with the global enable off must not suspend
    intReq = 1'b1;
    intEnable = 1'b0;
    send(CMD_WRITE, SRC_SELF, 8'h09, RSP_ACK);
    intReq = 1'b0;
    sess(1'b1);
    send(CMD_BLK_ERASE, SRC_SERIAL, 8'h14, RSP_NAK);
    send(CMD_WRITE, SRC_SERIAL, 8'h14, RSP_NAK);
    send(CMD_CHIP_ERASE, SRC_SERIAL, 8'h00, RSP_ACK);
    sess(1'b1);
    send(CMD_WRITE, SRC_SERIAL, 8'h14, RSP_ACK);
    cfgW = CFG_FACTORY;
    cfgW.chipProt = 1'b1;
    cfgW.boot0Prot = 1'b1;
    cfgW.bootSwap = 1'b1;
    cfgW.winEnd = 8'h09;
    send(CMD_SEC_SET, SRC_SERIAL, 8'h00, RSP_ACK);
    sess(1'b1);
    send(CMD_WRITE, SRC_SERIAL, 8'h14, RSP_ACK);
    send(CMD_BLK_ERASE, SRC_SERIAL, 8'h14, RSP_NAK);
    send(CMD_CHIP_ERASE, SRC_SERIAL, 8'h00, RSP_NAK);
    chk(bootSwapActive, 1'b1);
    sess(1'b0);
    mode(1'b1);
    send(CMD_WRITE, SRC_SELF, 8'h00, RSP_ACK);
    chk(gotBlk, 8'h04);
    send(CMD_WRITE, SRC_SELF, 8'h04, RSP_NAK);
    send(CMD_BLK_ERASE, SRC_SELF, 8'h08, RSP_ACK);
    chk(activeCfg.chipProt, 1'b1);
    // narrow the window from the self path; it acts from the next mode entry
    cfgW.winStart = 8'h08;
    send(CMD_SEC_SET, SRC_SELF, 8'h00, RSP_ACK);
    mode(1'b0);
    mode(1'b1);
    send(CMD_WRITE, SRC_SELF, 8'h02, RSP_NAK);
    mode(1'b0);
    give_verdict;
  end
endmodule
